// file: bench/pdl_top_assertions.sv
// Concurrent checks on the ports of the port data and LED sink top.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/10ps
module pdl_top_assertions (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [pdl_pkg::PDL_ADR_W-1:0] wb_adr_i,
  input wire logic [pdl_pkg::PDL_DAT_W-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [3:0][7:0] port_output_dir,
  input wire logic [3:0][7:0] alt_function_enable,
  input wire logic [3:0][7:0] open_drain_enable,
  input wire logic [3:0][7:0] pin_out,
  input wire logic [3:0][7:0] pin_oe,
  input wire logic [3:0][15:0] alt_function_code,
  input wire logic [7:0] led_sink_connect
);
  import pdl_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic led_wr;
  // Write to the sink enable register, seen at its acknowledge edge
  assign led_wr = wb_ack_o && wb_we_i && wb_adr_i[13:2] == PDL_LED_SINK_ENABLE_IDX;
  // ***************************************
  // Bus handshake
  // ***************************************
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == '0)
    else $error("read data outside ack");
  AST_DAT_UPPER: assert property (wb_ack_o |-> wb_dat_o[31:8] == '0)
    else $error("upper read bits not zero");
  // ***************************************
  // Pin drive and LED sink
  // ***************************************
  AST_OE_CAUSE: assert property ((pin_oe & ~$past(port_output_dir) & ~$past(alt_function_enable)) == '0)
    else $error("pad driven while input");
  AST_OD_LOW: assert property ((pin_oe & $past(open_drain_enable) & pin_out) == '0)
    else $error("open drain pad driven high");
  AST_ALT_GATE: assert property ($past(alt_function_enable) == '0 |-> alt_function_code == '0)
    else $error("alternate code without enable");
  AST_LED_CAUSE: assert property ($changed(led_sink_connect) |-> $past(led_wr, 1) || $past(led_wr, 2) || $past(led_wr, 3))
    else $error("sink connect changed without write");
  cover property (led_wr);
  cover property (wb_ack_o && !wb_we_i && wb_dat_o != '0);
  cover property ((pin_oe & open_drain_enable) != '0);
endmodule // pdl_top_assertions

bind pdl_top pdl_top_assertions u_chk (.sys_clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_o, .wb_ack_o, .port_output_dir, .alt_function_enable, .open_drain_enable,
  .pin_out, .pin_oe, .alt_function_code, .led_sink_connect);

// file: bench/pdl_top_tb.sv
// Self-checking bench for the port data and LED sink top.
// Assumes the checker is bound in; drives all ports as a Wishbone master.
`timescale 1ns/10ps
module pdl_top_tb;
  import pdl_pkg::*;
  // Port B modelled with its upper four pins absent
  localparam logic [3:0][7:0] PRESENT = {8'hff, 8'hff, 8'h0f, 8'hff};
  localparam logic [2:0][7:0] PINS = {8'hc3, 8'h69, 8'h96};
  localparam logic [7:0] LVL_HI = 8'hf0;
  localparam logic [7:0] LVL_LO = 8'hcc;
  localparam logic [2:0][11:0] IN_IDX = {PDL_PORT_C_INPUT_IDX, PDL_PORT_B_INPUT_IDX, PDL_PORT_A_INPUT_IDX};
  localparam logic [3:0][11:0] OUT_IDX = {PDL_PORT_D_OUTPUT_IDX, PDL_PORT_C_OUTPUT_IDX,
    PDL_PORT_B_OUTPUT_IDX, PDL_PORT_A_OUTPUT_IDX};
  localparam logic [6:0][11:0] RW_IDX = {PDL_LED_SINK_ENABLE_IDX, PDL_LED_LEVEL_HIGH_IDX,
    PDL_LED_LEVEL_LOW_IDX, PDL_PORT_A_OUTPUT_IDX, PDL_PORT_B_OUTPUT_IDX, PDL_PORT_C_OUTPUT_IDX,
    PDL_PORT_D_OUTPUT_IDX};
  logic sys_clk = 0, reset = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
  logic [13:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = '0;
  logic [31:0] wb_dat_i = '0, wb_dat_o, rd;
  logic [7:0] port_a_pin_in = '0, port_b_pin_in = '0, port_c_pin_in = '0, led_sink_connect, exp8;
  logic [3:0][7:0] port_output_dir = '0, alt_function_enable = '0, alt_function_select_one = '0;
  logic [3:0][7:0] alt_function_select_two = '0, open_drain_enable = '0, alt_function_out = '0;
  logic [3:0][7:0] alt_function_oe = '0, pin_out, pin_oe;
  logic [3:0][15:0] alt_function_code;
  logic [15:0] led_sink_level, exp16;
  int fails = 0, compares = 0, cycles = 0;
  pdl_top #(.PORT_B_PRESENT(8'h0f)) dut (.sys_clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .port_a_pin_in, .port_b_pin_in,
    .port_c_pin_in, .port_output_dir, .alt_function_enable, .alt_function_select_one,
    .alt_function_select_two, .open_drain_enable, .alt_function_out, .alt_function_oe, .pin_out,
    .pin_oe, .alt_function_code, .led_sink_connect, .led_sink_level);
  always #12.5 sys_clk = ~sys_clk;
  // ***************************************
  // Shared tasks
  // ***************************************
  task automatic final_report();
    $display("Compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 4000) begin
      fails++;
      final_report();
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Called at a rising edge; returns one edge after ack so cyc idles a cycle
  task automatic bus(input logic [11:0] idx, input logic w, input logic [7:0] d, input logic [3:0] s);
    int n;
    n = 0;
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= s;
    wb_dat_i <= {24'h0, d};
    @(posedge sys_clk);
    while (wb_ack_o !== 1'b1 && n < 20) begin
      @(posedge sys_clk);
      n++;
    end
    if (wb_ack_o !== 1'b1) begin
      fails++;
      final_report();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    wb_we_i <= 0;
    @(posedge sys_clk);
  endtask
  // ***************************************
  // Tests
  // ***************************************
  initial begin
    repeat (5) @(posedge sys_clk);
    reset <= 0;
    @(posedge sys_clk);
    for (int i = 0; i < 7; i++) begin
      bus(RW_IDX[i], 0, 8'h00, 4'h1);
      check("reset value", rd, 32'h0);
      bus(RW_IDX[i], 1, 8'h5a ^ 8'(i), 4'h1);
      bus(RW_IDX[i], 0, 8'h00, 4'h1);
      check("readback", rd, {24'h0, 8'h5a ^ 8'(i)});
    end
    // Lane 0 not selected, so the write must be dropped
    bus(RW_IDX[0], 1, 8'hff, 4'h0);
    bus(RW_IDX[0], 0, 8'h00, 4'h1);
    check("sel write", rd, 32'h5a);
    bus(12'h100, 1, 8'hff, 4'h1);
    bus(12'h100, 0, 8'h00, 4'h1);
    check("unmapped", rd, 32'h0);
    $display("Test registers done");
    port_a_pin_in <= PINS[0];
    port_b_pin_in <= PINS[1];
    port_c_pin_in <= PINS[2];
    repeat (5) @(posedge sys_clk);
    for (int p = 0; p < 3; p++) begin
      bus(IN_IDX[p], 1, ~PINS[p], 4'h1);
      bus(IN_IDX[p], 0, 8'h00, 4'h1);
      check("input", rd, {24'h0, PINS[p] & PRESENT[p]});
    end
    // A fresh pin level needs the sampler stages before it shows
    port_a_pin_in <= 8'h00;
    bus(IN_IDX[0], 0, 8'h00, 4'h1);
    check("input early", rd, {24'h0, PINS[0]});
    repeat (5) @(posedge sys_clk);
    bus(IN_IDX[0], 0, 8'h00, 4'h1);
    check("input late", rd, 32'h0);
    $display("Test inputs done");
    for (int p = 0; p < 4; p++)
      bus(OUT_IDX[p], 1, 8'ha5, 4'h1);
    for (int k = 0; k < 2; k++) begin
      @(posedge sys_clk);
      port_output_dir <= k ? {4{8'h3c}} : {4{8'hff}};
      alt_function_enable <= k ? {4{8'h00}} : {4{8'h0f}};
      open_drain_enable <= k ? {4{8'hff}} : {4{8'h30}};
      alt_function_out <= {4{8'h0a}};
      alt_function_oe <= {4{8'h0c}};
      alt_function_select_one <= {4{8'h55}};
      alt_function_select_two <= {4{8'h33}};
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      for (int p = 0; p < 4; p++) begin
        exp8 = PRESENT[p] & (port_output_dir[p] & ~alt_function_enable[p]
          & ~(open_drain_enable[p] & 8'ha5) | alt_function_enable[p] & alt_function_oe[p]
          & ~(open_drain_enable[p] & alt_function_out[p]));
        check("pin_oe", pin_oe[p], exp8);
        check("pin_out", pin_out[p] & exp8, (alt_function_enable[p] & alt_function_out[p]
          | ~alt_function_enable[p] & 8'ha5) & exp8);
        for (int n = 0; n < 8; n++)
          exp16[2*n +: 2] = alt_function_enable[p][n] ?
            {alt_function_select_two[p][n], alt_function_select_one[p][n]} : 2'b00;
        check("alt code", alt_function_code[p], exp16);
      end
    end
    $display("Test drive done");
    @(posedge sys_clk);
    alt_function_enable <= {4{8'hff}};
    bus(PDL_LED_SINK_ENABLE_IDX, 1, 8'h3c, 4'h1);
    bus(PDL_LED_LEVEL_HIGH_IDX, 1, LVL_HI, 4'h1);
    bus(PDL_LED_LEVEL_LOW_IDX, 1, LVL_LO, 4'h1);
    @(negedge sys_clk);
    check("led connect", led_sink_connect, 32'h3c);
    for (int n = 0; n < 8; n++)
      exp16[2*n +: 2] = {LVL_HI[n], LVL_LO[n]};
    check("led level", led_sink_level, exp16);
    $display("Test led done");
    final_report();
  end
endmodule // pdl_top_tb

// file: rtl/pdl_led_if.sv
// Carrier between the register file and the Port C LED sink stage.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps
interface pdl_led_if;
  logic [7:0] sink_enable;
  logic [7:0] level_high;
  logic [7:0] level_low;
  modport regs (output sink_enable, output level_high, output level_low);
  modport sink (input sink_enable, input level_high, input level_low);
endinterface

// file: rtl/pdl_led_sink.sv
// Port C LED current-sink control stage.
// Assumes the register side drives the interface from flip-flops.
`timescale 1ns/10ps
module pdl_led_sink (
  input wire logic sys_clk,
  input wire logic reset,
  pdl_led_if.sink led,
  output logic [7:0] sink_connect,
  output logic [15:0] sink_level
);
  import pdl_pkg::*;

  genvar g;
  generate
    for (g = 0; g < PDL_PINS; g++) begin : g_pin
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          sink_connect[g] <= 1'b0;
          sink_level[2*g+1 -: 2] <= 2'h0;
        end else begin
          // Alternate-function state is deliberately not an input here
          sink_connect[g] <= led.sink_enable[g];
          sink_level[2*g+1 -: 2] <= {led.level_high[g], led.level_low[g]};
        end
      end
    end
  endgenerate
endmodule // pdl_led_sink

// file: rtl/pdl_pkg.sv
// Shared constants for the port data and LED sink block.
// Assumes a 32-bit classic Wishbone bus with word-aligned registers.
package pdl_pkg;

  // ***************************************
  // Widths
  // ***************************************
  localparam int PDL_PINS = 8;
  localparam int PDL_ADR_W = 14;
  localparam int PDL_DAT_W = 32;
  localparam int PDL_IDX_W = 12;
  localparam int PDL_SYNC_STAGES = 3;

  // ***************************************
  // Register indices (byte address = index * 4)
  // ***************************************
  localparam logic [11:0] PDL_LED_SINK_ENABLE_IDX = 12'hf82;
  localparam logic [11:0] PDL_LED_LEVEL_HIGH_IDX = 12'hf83;
  localparam logic [11:0] PDL_LED_LEVEL_LOW_IDX = 12'hf84;
  localparam logic [11:0] PDL_PORT_A_INPUT_IDX = 12'hfd2;
  localparam logic [11:0] PDL_PORT_A_OUTPUT_IDX = 12'hfd3;
  localparam logic [11:0] PDL_PORT_B_INPUT_IDX = 12'hfd6;
  localparam logic [11:0] PDL_PORT_B_OUTPUT_IDX = 12'hfd7;
  localparam logic [11:0] PDL_PORT_C_INPUT_IDX = 12'hfda;
  localparam logic [11:0] PDL_PORT_C_OUTPUT_IDX = 12'hfdb;
  localparam logic [11:0] PDL_PORT_D_OUTPUT_IDX = 12'hfdf;

  // ***************************************
  // Reset values and fixed read values
  // ***************************************
  localparam logic [7:0] PDL_REG_RESET = 8'h00;
  localparam logic [7:0] PDL_ALL_PINS = 8'hff;
  localparam logic [31:0] PDL_READ_ZERO = 32'h0000_0000;
  localparam logic [1:0] PDL_ALT_NONE = 2'h0;
  localparam int PDL_LANE0_LSB = 0;

  // Decoded register selection
  typedef enum {
    PDL_SEL_NONE,
    PDL_SEL_LED_EN,
    PDL_SEL_LED_HI,
    PDL_SEL_LED_LO,
    PDL_SEL_A_IN,
    PDL_SEL_A_OUT,
    PDL_SEL_B_IN,
    PDL_SEL_B_OUT,
    PDL_SEL_C_IN,
    PDL_SEL_C_OUT,
    PDL_SEL_D_OUT
  } pdl_sel_t;

  // Bus slave states
  typedef enum {
    PDL_BUS_IDLE,
    PDL_BUS_ACK
  } pdl_bus_state_t;

endpackage

// file: rtl/pdl_sync.sv
// Pin input sampler: three flip-flops per bit, value taken when the
// second and third stages agree. Assumes asynchronous pin inputs.
`timescale 1ns/10ps
module pdl_sync (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] pin_raw,
  output logic [7:0] pin_sampled
);
  import pdl_pkg::*;

  logic [7:0] meta_reg;
  logic [7:0] stage2_reg;
  logic [7:0] stage3_reg;

  // Only stage2 reads meta_reg, keeping the metastable node isolated
  always_ff @(posedge sys_clk) begin
    meta_reg <= pin_raw;
    stage2_reg <= meta_reg;
    stage3_reg <= stage2_reg;
  end

  genvar g;
  generate
    for (g = 0; g < PDL_PINS; g++) begin : g_bit
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          pin_sampled[g] <= 1'b0;
        end else if (stage2_reg[g] == stage3_reg[g]) begin
          pin_sampled[g] <= stage3_reg[g];
        end
      end
    end
  endgenerate
endmodule // pdl_sync

// file: rtl/pdl_top.sv
// Overview of operation
// - Input registers return sampled pin levels, one bit per pin, 1 high.
// - Input registers are read-only; writes there change nothing.
// - Bits of pins absent in the package variant read zero; only input registers do here, output registers read back all eight bits.
// - Output registers hold eight read/write drive bits, zero at reset.
// - Output bit drives pin only when output and not alternate function.
// - With open-drain set, a 1 leaves the pin undriven; 0 drives low.
// - LED enable bit n controls Port C pin n.
// - LED sink depends only on its enable, never alternate-function selection.
// - LED enable 0 disconnects sink, 1 connects it; resets to zero.
// - Level-high and level-low bits form code 00..11, lowest to highest.
// - Level registers are eight read/write bits, zero at reset, per pin.
// - Alternate function applies only when its enable bit is set.
//
// Top of the port data path and LED sink block, classic Wishbone slave.
// Assumes direction, alternate-function and open-drain controls come from
// the rest of the port unit on the same clock.
`timescale 1ns/10ps
module pdl_top #(
  parameter logic [7:0] PORT_A_PRESENT = 8'hff,
  parameter logic [7:0] PORT_B_PRESENT = 8'hff,
  parameter logic [7:0] PORT_C_PRESENT = 8'hff,
  parameter logic [7:0] PORT_D_PRESENT = 8'hff
) (
  input wire logic sys_clk,
  input wire logic reset,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [pdl_pkg::PDL_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [pdl_pkg::PDL_DAT_W-1:0] wb_dat_i,
  output logic [pdl_pkg::PDL_DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Raw pin levels
  input wire logic [7:0] port_a_pin_in,
  input wire logic [7:0] port_b_pin_in,
  input wire logic [7:0] port_c_pin_in,
  // Controls from the rest of the port unit, index 0..3 = ports A..D
  input wire logic [3:0][7:0] port_output_dir,
  input wire logic [3:0][7:0] alt_function_enable,
  input wire logic [3:0][7:0] alt_function_select_one,
  input wire logic [3:0][7:0] alt_function_select_two,
  input wire logic [3:0][7:0] open_drain_enable,
  input wire logic [3:0][7:0] alt_function_out,
  input wire logic [3:0][7:0] alt_function_oe,
  // Pin drive
  output logic [3:0][7:0] pin_out,
  output logic [3:0][7:0] pin_oe,
  output logic [3:0][15:0] alt_function_code,
  // LED sink
  output logic [7:0] led_sink_connect,
  output logic [15:0] led_sink_level
);
  import pdl_pkg::*;

  // ***************************************
  // Address decode
  // ***************************************

  function automatic pdl_sel_t decode_index(input logic [PDL_IDX_W-1:0] idx);
    pdl_sel_t sel;
    sel = PDL_SEL_NONE;
    case (idx)
      PDL_LED_SINK_ENABLE_IDX: sel = PDL_SEL_LED_EN;
      PDL_LED_LEVEL_HIGH_IDX: sel = PDL_SEL_LED_HI;
      PDL_LED_LEVEL_LOW_IDX: sel = PDL_SEL_LED_LO;
      PDL_PORT_A_INPUT_IDX: sel = PDL_SEL_A_IN;
      PDL_PORT_A_OUTPUT_IDX: sel = PDL_SEL_A_OUT;
      PDL_PORT_B_INPUT_IDX: sel = PDL_SEL_B_IN;
      PDL_PORT_B_OUTPUT_IDX: sel = PDL_SEL_B_OUT;
      PDL_PORT_C_INPUT_IDX: sel = PDL_SEL_C_IN;
      PDL_PORT_C_OUTPUT_IDX: sel = PDL_SEL_C_OUT;
      PDL_PORT_D_OUTPUT_IDX: sel = PDL_SEL_D_OUT;
      default: sel = PDL_SEL_NONE;
    endcase
    return sel;
  endfunction

  // Reused by every writable register: the bus strobe and the selection must meet
  function automatic logic write_hit(input pdl_sel_t target, input pdl_sel_t sel,
                                     input logic strobe);
    return strobe && (sel == target);
  endfunction

  logic [PDL_IDX_W-1:0] bus_index;
  pdl_sel_t bus_sel;
  logic bus_request;
  logic bus_write;

  assign bus_index = wb_adr_i[PDL_ADR_W-1:2];
  assign bus_sel = decode_index(bus_index);

  // ***************************************
  // Wishbone handshake
  // ***************************************

  // One wait state: the request is taken in IDLE, answered in ACK.
  // Dropping ack after one cycle stops a held request from writing on consecutive edges.
  pdl_bus_state_t bus_state_reg;
  pdl_bus_state_t bus_state_next;

  assign bus_request = wb_cyc_i && wb_stb_i;

  always_comb begin
    bus_state_next = bus_state_reg;
    case (bus_state_reg)
      PDL_BUS_IDLE: begin
        if (bus_request) begin
          bus_state_next = PDL_BUS_ACK;
        end
      end
      PDL_BUS_ACK: bus_state_next = PDL_BUS_IDLE;
      default: bus_state_next = PDL_BUS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bus_state_reg <= PDL_BUS_IDLE;
    end else begin
      bus_state_reg <= bus_state_next;
    end
  end

  assign wb_ack_o = (bus_state_reg == PDL_BUS_ACK);

  // Writes land on the edge where ack is seen by the master
  assign bus_write = wb_ack_o && bus_request && wb_we_i && wb_sel_i[0];

  // ***************************************
  // Register write strobes
  // ***************************************

  // No strobe exists for the input registers, so a write there changes nothing
  logic [3:0] out_write;
  logic led_en_write;
  logic led_hi_write;
  logic led_lo_write;

  assign led_en_write = write_hit(PDL_SEL_LED_EN, bus_sel, bus_write);
  assign led_hi_write = write_hit(PDL_SEL_LED_HI, bus_sel, bus_write);
  assign led_lo_write = write_hit(PDL_SEL_LED_LO, bus_sel, bus_write);

  // ***************************************
  // Input sampling
  // ***************************************

  logic [7:0] port_a_sampled;
  logic [7:0] port_b_sampled;
  logic [7:0] port_c_sampled;

  pdl_sync u_sync_a (
    .sys_clk(sys_clk),
    .reset(reset),
    .pin_raw(port_a_pin_in),
    .pin_sampled(port_a_sampled)
  );

  pdl_sync u_sync_b (
    .sys_clk(sys_clk),
    .reset(reset),
    .pin_raw(port_b_pin_in),
    .pin_sampled(port_b_sampled)
  );

  pdl_sync u_sync_c (
    .sys_clk(sys_clk),
    .reset(reset),
    .pin_raw(port_c_pin_in),
    .pin_sampled(port_c_sampled)
  );

  logic [7:0] port_a_input_value;
  logic [7:0] port_b_input_value;
  logic [7:0] port_c_input_value;

  // Port D has no input register, so it needs no sampler
  // Absent pins are forced low so a floating pad cannot leak in
  assign port_a_input_value = port_a_sampled & PORT_A_PRESENT;
  assign port_b_input_value = port_b_sampled & PORT_B_PRESENT;
  assign port_c_input_value = port_c_sampled & PORT_C_PRESENT;

  // ***************************************
  // Output data registers
  // ***************************************

  // Index 0..3 follows ports A..D, as on the control inputs
  logic [3:0][7:0] port_output_value_reg;
  pdl_sel_t out_sel [4];

  assign out_sel[0] = PDL_SEL_A_OUT;
  assign out_sel[1] = PDL_SEL_B_OUT;
  assign out_sel[2] = PDL_SEL_C_OUT;
  assign out_sel[3] = PDL_SEL_D_OUT;

  genvar p;
  generate
    for (p = 0; p < 4; p++) begin : g_out_reg
      assign out_write[p] = write_hit(out_sel[p], bus_sel, bus_write);

      always_ff @(posedge sys_clk) begin
        if (reset) begin
          port_output_value_reg[p] <= PDL_REG_RESET;
        end else if (out_write[p]) begin
          port_output_value_reg[p] <= wb_dat_i[PDL_LANE0_LSB +: 8];
        end
      end
    end
  endgenerate

  // ***************************************
  // LED sink registers
  // ***************************************

  logic [7:0] led_sink_enable_reg;
  logic [7:0] led_level_high_bits_reg;
  logic [7:0] led_level_low_bits_reg;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      led_sink_enable_reg <= PDL_REG_RESET;
    end else if (led_en_write) begin
      led_sink_enable_reg <= wb_dat_i[PDL_LANE0_LSB +: 8];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      led_level_high_bits_reg <= PDL_REG_RESET;
    end else if (led_hi_write) begin
      led_level_high_bits_reg <= wb_dat_i[PDL_LANE0_LSB +: 8];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      led_level_low_bits_reg <= PDL_REG_RESET;
    end else if (led_lo_write) begin
      led_level_low_bits_reg <= wb_dat_i[PDL_LANE0_LSB +: 8];
    end
  end

  // The sink stage registers the controls again, so a write shows one edge later
  pdl_led_if led_bus ();

  assign led_bus.sink_enable = led_sink_enable_reg;
  assign led_bus.level_high = led_level_high_bits_reg;
  assign led_bus.level_low = led_level_low_bits_reg;

  pdl_led_sink u_led_sink (
    .sys_clk(sys_clk),
    .reset(reset),
    .led(led_bus.sink),
    .sink_connect(led_sink_connect),
    .sink_level(led_sink_level)
  );

  // ***************************************
  // Read data
  // ***************************************

  // Input registers have no write path at all, so writes there are dropped
  logic [7:0] read_byte;

  always_comb begin
    read_byte = PDL_REG_RESET;
    case (bus_sel)
      PDL_SEL_LED_EN: read_byte = led_sink_enable_reg;
      PDL_SEL_LED_HI: read_byte = led_level_high_bits_reg;
      PDL_SEL_LED_LO: read_byte = led_level_low_bits_reg;
      PDL_SEL_A_IN: read_byte = port_a_input_value;
      PDL_SEL_A_OUT: read_byte = port_output_value_reg[0];
      PDL_SEL_B_IN: read_byte = port_b_input_value;
      PDL_SEL_B_OUT: read_byte = port_output_value_reg[1];
      PDL_SEL_C_IN: read_byte = port_c_input_value;
      PDL_SEL_C_OUT: read_byte = port_output_value_reg[2];
      PDL_SEL_D_OUT: read_byte = port_output_value_reg[3];
      default: read_byte = PDL_REG_RESET;
    endcase
  end

  // Bits 31:8 are not implemented and always read as zero
  // Read data is captured when the request is taken and held through ack
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wb_dat_o <= PDL_READ_ZERO;
    end else if (bus_state_reg == PDL_BUS_IDLE && bus_request) begin
      wb_dat_o <= {24'h00_0000, read_byte};
    end else if (bus_state_reg == PDL_BUS_ACK) begin
      wb_dat_o <= PDL_READ_ZERO;
    end
  end

  // ***************************************
  // Pin drive
  // ***************************************

  // Absent pads are never enabled, whatever the port unit asks for
  logic [3:0][7:0] port_present;

  assign port_present[0] = PORT_A_PRESENT;
  assign port_present[1] = PORT_B_PRESENT;
  assign port_present[2] = PORT_C_PRESENT;
  assign port_present[3] = PORT_D_PRESENT;

  genvar b;
  generate
    for (p = 0; p < 4; p++) begin : g_port
      for (b = 0; b < PDL_PINS; b++) begin : g_pin
        logic alt_active;
        logic gpio_drive;
        logic drive_value;
        logic drive_enable;

        // Select bits alone never hand the pin to a peripheral
        assign alt_active = alt_function_enable[p][b];
        assign gpio_drive = port_output_dir[p][b] && !alt_active;
        assign drive_value = alt_active ? alt_function_out[p][b]
                                        : port_output_value_reg[p][b];
        // Open drain only ever pulls low; a 1 releases the pad
        assign drive_enable = (alt_active ? alt_function_oe[p][b] : gpio_drive)
                              && !(open_drain_enable[p][b] && drive_value);

        always_ff @(posedge sys_clk) begin
          if (reset) begin
            pin_out[p][b] <= 1'b0;
            pin_oe[p][b] <= 1'b0;
            alt_function_code[p][2*b+1 -: 2] <= PDL_ALT_NONE;
          end else begin
            pin_out[p][b] <= drive_value;
            pin_oe[p][b] <= drive_enable && port_present[p][b];
            alt_function_code[p][2*b+1 -: 2] <= alt_active
                ? {alt_function_select_two[p][b], alt_function_select_one[p][b]}
                : PDL_ALT_NONE;
          end
        end
      end
    end
  endgenerate

endmodule // pdl_top
